// ===== rtl/perf_defs.svh
/*
 Constants of the error performance accounting block: field widths,
 judgment lengths, threshold exponents and reset values.
 Assumes nothing; holds definitions only.
*/
`ifndef PERF_DEFS_SVH
`define PERF_DEFS_SVH

// Per-interval pulse count widths
`define PERF_ERR_W      32
`define PERF_CLK_W      40

// Consecutive intervals needed to confirm a period change
`define PERF_JUDGE_LEN  4'd10

// Intervals per degraded-minute block
`define PERF_DM_BLOCK   7'd60

// Threshold exponents (ratio above 10 to the minus n) and number of interval thresholds
`define PERF_EXP_FIRST  3
`define PERF_THR_NUM    6
`define PERF_EXP_DM_LO  6
`define PERF_EXP_DM_HI  8

// Reset value of every counter
`define PERF_CNT_RST    '0

`endif

// ===== rtl/perf_pkg.sv
/*
 Types of the error performance accounting block.
 Assumes perf_defs.svh is on the include path.
*/
`include "perf_defs.svh"

package perf_pkg;

	// Availability tracker states
	typedef enum logic [1:0] {
		AV_CONF,
		AV_JUDG,
		UN_CONF,
		UN_JUDG
	} avail_state_e;

	// One closed interval from the error detection front end
	typedef struct packed {
		logic                   power_fail;
		logic                   clock_loss;
		logic                   sync_loss;
		logic [`PERF_ERR_W-1:0] err_cnt;
		logic [`PERF_CLK_W-1:0] clk_cnt;
	} interval_s;

	// Static switch settings
	typedef struct packed {
		logic clock_loss_eval_select;
		logic sync_loss_eval_select;
		logic availability_threshold_select;
	} perf_cfg_s;

endpackage

// ===== rtl/ratio_above.sv
/*
 Compares an error count scaled by a power of ten against a clock
 count: high when err / clk exceeds 10 to the minus EXP.
 Assumes both counts are stable in the cycle they are sampled.
*/
`timescale 1ns/100ps
`default_nettype none

module ratio_above #(
	parameter int EXP = 3,
	parameter int EW  = 32,
	parameter int CW  = 40
) (
	// Counts
	input  wire logic [EW-1:0] err,
	input  wire logic [CW-1:0] clk,
	// Result
	output logic               above
);

	function automatic longint pow10(input int n);
		longint p;
		p = 1;
		for (int i = 0; i < n; i++) begin
			p = p * 10;
		end
		return p;
	endfunction

	localparam int SW = 30;
	localparam int PW = ((EW + SW > CW) ? EW + SW : CW) + 1;
	localparam logic [SW-1:0] SCALE = SW'(pow10(EXP));

	wire logic [PW-1:0] prod;
	wire logic [PW-1:0] base;

	// Cross-multiplied compare avoids a divider
	assign prod  = PW'(err) * PW'(SCALE);
	assign base  = PW'(clk);
	assign above = prod > base;

endmodule

`default_nettype wire

// ===== rtl/error_performance_accounting.sv
/*
 Error performance accounting: classifies each closed one-second
 interval, keeps threshold interval counts, runs the availability
 tracker and books available, unavailable, errored, severely errored
 and degraded-minute figures. Ratios are formed by the reader from
 the numerator and denominator counts driven here.
 Assumes the front end presents interval data together with a one
 cycle interval_tick, synchronous to core_clk.
*/
`timescale 1ns/100ps
`include "perf_defs.svh"
`default_nettype none

module error_performance_accounting
	import perf_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int SUM_W = 64
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// Measurement control
	input  wire logic                     meas_clear,
	input  wire logic                     meas_run,
	input  wire perf_cfg_s                cfg,
	// Interval data from the front end
	input  wire logic                     interval_tick,
	input  wire interval_s                ivl,
	// Error measurement
	output logic [SUM_W-1:0]              total_error_pulses,
	output logic [SUM_W-1:0]              total_clock_pulses,
	output logic [CNT_W-1:0]              errored_interval_count,
	output logic [CNT_W-1:0]              total_interval_count,
	output logic [CNT_W-1:0]              measure_seconds,
	output logic [`PERF_THR_NUM:0][CNT_W-1:0] threshold_ei_count,
	// Alarm intervals
	output logic [CNT_W-1:0]              power_fail_intervals,
	output logic [CNT_W-1:0]              clock_loss_intervals,
	output logic [CNT_W-1:0]              sync_loss_intervals,
	// Error performance
	output logic [CNT_W-1:0]              available_seconds,
	output logic [CNT_W-1:0]              unavailable_seconds,
	output logic [CNT_W-1:0]              errored_seconds,
	output logic [CNT_W-1:0]              severe_seconds,
	output logic [CNT_W-1:0]              dm_blocks,
	output logic [CNT_W-1:0]              dm_exceed_blocks,
	output avail_state_e                  avail_state
);

	localparam int EW = `PERF_ERR_W;
	localparam int CW = `PERF_CLK_W;
	localparam int NT = `PERF_THR_NUM;
	localparam int PEW = EW + 4;
	localparam int PCW = CW + 4;
	localparam int BEW = EW + 7;
	localparam int BCW = CW + 7;

	////////////////////////////////////////////////////////////////////
	// Interval classification

	wire logic tick_run;
	wire logic pf_ivl;
	wire logic cl_ivl;
	wire logic sl_ivl;
	wire logic normal_ivl;
	wire logic drop_ivl;
	wire logic forced_unav;
	wire logic judged_ivl;
	wire logic has_err;
	wire logic unav_ivl;
	wire logic errored_now;
	wire logic [EW-1:0] cur_err;
	wire logic [CW-1:0] cur_clk;
	wire logic [NT-1:0] thr_above;

	// Interval is tagged with its alarm status at the closing tick
	assign tick_run    = interval_tick & meas_run;
	assign pf_ivl      = tick_run & ivl.power_fail;
	assign cl_ivl      = tick_run & ~ivl.power_fail & ivl.clock_loss;
	assign sl_ivl      = tick_run & ~ivl.power_fail & ~ivl.clock_loss
	                   & ivl.sync_loss;
	assign normal_ivl  = tick_run & ~ivl.power_fail & ~ivl.clock_loss
	                   & ~ivl.sync_loss;
	// Alarm intervals that leave the tracker and restart it
	assign drop_ivl    = pf_ivl
	                   | (cl_ivl & ~cfg.clock_loss_eval_select)
	                   | (sl_ivl & ~cfg.sync_loss_eval_select);
	// Alarm intervals that enter the tracker as unavailable
	assign forced_unav = (cl_ivl & cfg.clock_loss_eval_select)
	                   | (sl_ivl & cfg.sync_loss_eval_select);
	assign judged_ivl  = normal_ivl | forced_unav;
	// Alarm interval pulse counts never reach any sum
	assign cur_err     = normal_ivl ? ivl.err_cnt : '0;
	assign cur_clk     = normal_ivl ? ivl.clk_cnt : '0;
	assign has_err     = normal_ivl & (ivl.err_cnt != '0);
	// Threshold pair chosen by the select switch
	assign unav_ivl    = forced_unav | (normal_ivl
	                   & (cfg.availability_threshold_select ?
	                      thr_above[1] : thr_above[0]));
	assign errored_now = has_err | forced_unav;

	// Interval ratio against each fixed threshold
	generate
		for (genvar g = 0; g < NT; g++) begin : g_thr
			ratio_above #(
				.EXP (`PERF_EXP_FIRST + g),
				.EW  (EW),
				.CW  (CW)
			) u_thr (
				.err   (ivl.err_cnt),
				.clk   (ivl.clk_cnt),
				.above (thr_above[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Availability tracker

	avail_state_e       st_q;
	avail_state_e       st_d;
	logic [3:0]         pend_n_q;
	logic [3:0]         pend_n_d;
	logic [3:0]         pend_e_q;
	logic [3:0]         pend_e_d;
	logic [PEW-1:0]     pend_err_q;
	logic [PEW-1:0]     pend_err_d;
	logic [PCW-1:0]     pend_clk_q;
	logic [PCW-1:0]     pend_clk_d;
	logic [3:0]         bk_av;
	logic [3:0]         bk_un;
	logic [3:0]         bk_err;
	logic [3:0]         bk_ses;
	logic [3:0]         bk_dm;
	logic [PEW-1:0]     bk_dm_err;
	logic [PCW-1:0]     bk_dm_clk;

	// Next state and the seconds booked by this interval
	always_comb begin
		st_d       = st_q;
		pend_n_d   = pend_n_q;
		pend_e_d   = pend_e_q;
		pend_err_d = pend_err_q;
		pend_clk_d = pend_clk_q;
		bk_av      = '0;
		bk_un      = '0;
		bk_err     = '0;
		bk_ses     = '0;
		bk_dm      = '0;
		bk_dm_err  = '0;
		bk_dm_clk  = '0;
		if (drop_ivl) begin
			// Pending judgment is dropped and the tracker restarts
			st_d       = AV_CONF;
			pend_n_d   = '0;
			pend_e_d   = '0;
			pend_err_d = '0;
			pend_clk_d = '0;
		end else if (judged_ivl) begin
			case (st_q)
				AV_CONF: begin
					if (!unav_ivl) begin
						bk_av     = 4'd1;
						bk_err    = {3'b000, errored_now};
						bk_dm     = 4'd1;
						bk_dm_err = PEW'(cur_err);
						bk_dm_clk = PCW'(cur_clk);
					end else begin
						st_d     = AV_JUDG;
						pend_n_d = 4'd1;
					end
				end
				AV_JUDG: begin
					if (!unav_ivl) begin
						// Pending unavailable intervals become severe
						bk_av     = pend_n_q + 4'd1;
						bk_err    = pend_n_q + {3'b000, errored_now};
						bk_ses    = pend_n_q;
						bk_dm     = 4'd1;
						bk_dm_err = PEW'(cur_err);
						bk_dm_clk = PCW'(cur_clk);
						st_d      = AV_CONF;
						pend_n_d  = '0;
					end else if (pend_n_q == `PERF_JUDGE_LEN - 4'd1) begin
						bk_un    = `PERF_JUDGE_LEN;
						st_d     = UN_CONF;
						pend_n_d = '0;
					end else begin
						pend_n_d = pend_n_q + 4'd1;
					end
				end
				UN_CONF: begin
					if (unav_ivl) begin
						bk_un = 4'd1;
					end else begin
						st_d       = UN_JUDG;
						pend_n_d   = 4'd1;
						pend_e_d   = {3'b000, errored_now};
						pend_err_d = PEW'(cur_err);
						pend_clk_d = PCW'(cur_clk);
					end
				end
				UN_JUDG: begin
					if (unav_ivl) begin
						bk_un      = pend_n_q + 4'd1;
						st_d       = UN_CONF;
						pend_n_d   = '0;
						pend_e_d   = '0;
						pend_err_d = '0;
						pend_clk_d = '0;
					end else if (pend_n_q == `PERF_JUDGE_LEN - 4'd1) begin
						// Ten available intervals close the period
						bk_av      = `PERF_JUDGE_LEN;
						bk_err     = pend_e_q + {3'b000, errored_now};
						bk_dm      = `PERF_JUDGE_LEN;
						bk_dm_err  = pend_err_q + PEW'(cur_err);
						bk_dm_clk  = pend_clk_q + PCW'(cur_clk);
						st_d       = AV_CONF;
						pend_n_d   = '0;
						pend_e_d   = '0;
						pend_err_d = '0;
						pend_clk_d = '0;
					end else begin
						pend_n_d   = pend_n_q + 4'd1;
						pend_e_d   = pend_e_q + {3'b000, errored_now};
						pend_err_d = pend_err_q + PEW'(cur_err);
						pend_clk_d = pend_clk_q + PCW'(cur_clk);
					end
				end
				default: begin
					st_d     = AV_CONF;
					pend_n_d = '0;
				end
			endcase
		end
	end

	// Tracker state registers
	always_ff @(posedge core_clk) begin
		if (rst || meas_clear) begin
			st_q       <= AV_CONF;
			pend_n_q   <= '0;
			pend_e_q   <= '0;
			pend_err_q <= '0;
			pend_clk_q <= '0;
		end else begin
			st_q       <= st_d;
			pend_n_q   <= pend_n_d;
			pend_e_q   <= pend_e_d;
			pend_err_q <= pend_err_d;
			pend_clk_q <= pend_clk_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Degraded-minute blocks

	logic [6:0]     blk_n_q;
	logic [BEW-1:0] blk_err_q;
	logic [BCW-1:0] blk_clk_q;
	wire logic [6:0]     blk_n_sum;
	wire logic [BEW-1:0] blk_err_sum;
	wire logic [BCW-1:0] blk_clk_sum;
	wire logic           blk_close;
	wire logic           dm_lo_above;
	wire logic           dm_hi_above;
	wire logic           dm_above;

	// Available non-severe intervals gathered into blocks
	assign blk_n_sum   = blk_n_q + {3'b000, bk_dm};
	assign blk_err_sum = blk_err_q + BEW'(bk_dm_err);
	assign blk_clk_sum = blk_clk_q + BCW'(bk_dm_clk);
	assign blk_close   = (bk_dm != '0) && (blk_n_sum >= `PERF_DM_BLOCK);
	assign dm_above    = cfg.availability_threshold_select ?
	                     dm_hi_above : dm_lo_above;

	ratio_above #(
		.EXP (`PERF_EXP_DM_LO),
		.EW  (BEW),
		.CW  (BCW)
	) u_dm_lo (
		.err   (blk_err_sum),
		.clk   (blk_clk_sum),
		.above (dm_lo_above)
	);

	ratio_above #(
		.EXP (`PERF_EXP_DM_HI),
		.EW  (BEW),
		.CW  (BCW)
	) u_dm_hi (
		.err   (blk_err_sum),
		.clk   (blk_clk_sum),
		.above (dm_hi_above)
	);

	// Block accumulator; a closed block restarts from empty
	always_ff @(posedge core_clk) begin
		if (rst || meas_clear || blk_close) begin
			blk_n_q   <= '0;
			blk_err_q <= '0;
			blk_clk_q <= '0;
		end else if (bk_dm != '0) begin
			blk_n_q   <= blk_n_sum;
			blk_err_q <= blk_err_sum;
			blk_clk_q <= blk_clk_sum;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result counters

	// Error measurement and threshold intervals
	always_ff @(posedge core_clk) begin
		if (rst || meas_clear) begin
			total_error_pulses     <= `PERF_CNT_RST;
			total_clock_pulses     <= `PERF_CNT_RST;
			errored_interval_count <= `PERF_CNT_RST;
			total_interval_count   <= `PERF_CNT_RST;
			measure_seconds        <= `PERF_CNT_RST;
			threshold_ei_count     <= `PERF_CNT_RST;
		end else begin
			total_error_pulses <= total_error_pulses + SUM_W'(cur_err);
			total_clock_pulses <= total_clock_pulses + SUM_W'(cur_clk);
			measure_seconds    <= measure_seconds + CNT_W'(tick_run);
			errored_interval_count <= errored_interval_count
			                        + CNT_W'(has_err);
			// Evaluated alarm intervals join the total only
			total_interval_count <= total_interval_count
			                      + CNT_W'(judged_ivl);
			for (int i = 0; i < NT; i++) begin
				threshold_ei_count[i] <= threshold_ei_count[i]
				    + CNT_W'(normal_ivl & thr_above[i]);
			end
			threshold_ei_count[NT] <= threshold_ei_count[NT]
			    + CNT_W'(normal_ivl & ~thr_above[NT-1]);
		end
	end

	// Alarm interval counts
	always_ff @(posedge core_clk) begin
		if (rst || meas_clear) begin
			power_fail_intervals <= `PERF_CNT_RST;
			clock_loss_intervals <= `PERF_CNT_RST;
			sync_loss_intervals  <= `PERF_CNT_RST;
		end else begin
			power_fail_intervals <= power_fail_intervals
			                      + CNT_W'(pf_ivl);
			clock_loss_intervals <= clock_loss_intervals
			                      + CNT_W'(cl_ivl);
			sync_loss_intervals  <= sync_loss_intervals
			                      + CNT_W'(sl_ivl);
		end
	end

	// Booked seconds; all items but unavailable_seconds accrue only from available bookings
	always_ff @(posedge core_clk) begin
		if (rst || meas_clear) begin
			available_seconds   <= `PERF_CNT_RST;
			unavailable_seconds <= `PERF_CNT_RST;
			errored_seconds     <= `PERF_CNT_RST;
			severe_seconds      <= `PERF_CNT_RST;
			dm_blocks           <= `PERF_CNT_RST;
			dm_exceed_blocks    <= `PERF_CNT_RST;
		end else begin
			available_seconds   <= available_seconds + CNT_W'(bk_av);
			unavailable_seconds <= unavailable_seconds
			                     + CNT_W'(bk_un);
			errored_seconds     <= errored_seconds + CNT_W'(bk_err);
			severe_seconds      <= severe_seconds + CNT_W'(bk_ses);
			dm_blocks           <= dm_blocks + CNT_W'(blk_close);
			dm_exceed_blocks    <= dm_exceed_blocks
			                     + CNT_W'(blk_close & dm_above);
		end
	end

	// Tracker state seen from outside
	always_ff @(posedge core_clk) begin
		if (rst || meas_clear) begin
			avail_state <= AV_CONF;
		end else begin
			avail_state <= st_d;
		end
	end

endmodule

`default_nettype wire

// ===== dv/epa_monitor.sv
/*
 Port checker of the error performance accounting block.
 Assumes it is bound to the block and sees its ports only.
*/
`timescale 1ns/100ps
`include "perf_defs.svh"
`default_nettype none

module epa_monitor
	import perf_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int SUM_W = 64
) (
	// Clock, reset and control
	input wire logic                      core_clk,
	input wire logic                      rst,
	input wire logic                      meas_clear,
	input wire logic                      meas_run,
	input wire perf_cfg_s                 cfg,
	// Interval port
	input wire logic                      interval_tick,
	input wire interval_s                 ivl,
	// Results
	input wire logic [SUM_W-1:0]          total_error_pulses,
	input wire logic [CNT_W-1:0]          errored_interval_count,
	input wire logic [CNT_W-1:0]          total_interval_count,
	input wire logic [CNT_W-1:0]          measure_seconds,
	input wire logic [`PERF_THR_NUM:0][CNT_W-1:0] threshold_ei_count,
	input wire logic [CNT_W-1:0]          power_fail_intervals,
	input wire logic [CNT_W-1:0]          clock_loss_intervals,
	input wire logic [CNT_W-1:0]          sync_loss_intervals,
	input wire logic [CNT_W-1:0]          available_seconds,
	input wire logic [CNT_W-1:0]          unavailable_seconds,
	input wire avail_state_e              avail_state
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Interval classes seen at the port
	wire logic take  = interval_tick && meas_run && !meas_clear;
	wire logic alarm = ivl.power_fail | ivl.clock_loss | ivl.sync_loss;
	wire logic norm  = take && !alarm;
	wire logic clean = norm && (ivl.err_cnt == '0);
	// Ratio above 1e-3 is unavailable under either threshold select
	wire logic hard  = norm
		&& (64'(ivl.err_cnt) * 64'd1000 > 64'(ivl.clk_cnt));
	wire logic cl_in = take && !ivl.power_fail && ivl.clock_loss;
	wire logic sl_in = take && !ivl.power_fail && !ivl.clock_loss
		&& ivl.sync_loss;

	////////////////////////////////////////////////////////////////////
	clear_init_a: assert property (meas_clear && !interval_tick |=>
		avail_state == AV_CONF && available_seconds == '0
		&& measure_seconds == '0) else $error("clear did not restart");
	idle_hold_a: assert property (!take && !meas_clear |=>
		$stable(measure_seconds) && $stable(avail_state)
		&& $stable(total_interval_count)) else $error("idle change");
	second_count_a: assert property (take |=>
		measure_seconds == $past(measure_seconds) + 1'b1)
		else $error("measurement time miscounted");
	power_drop_a: assert property (take && ivl.power_fail |=>
		avail_state == AV_CONF && $stable(available_seconds)
		&& $stable(unavailable_seconds) && $stable(total_error_pulses)
		&& power_fail_intervals == $past(power_fail_intervals) + 1'b1)
		else $error("power fail interval mishandled");
	clock_drop_a: assert property (cl_in && !cfg.clock_loss_eval_select |=>
		avail_state == AV_CONF && $stable(available_seconds)
		&& $stable(total_interval_count)
		&& clock_loss_intervals == $past(clock_loss_intervals) + 1'b1)
		else $error("clock loss drop mishandled");
	clock_eval_a: assert property (cl_in && cfg.clock_loss_eval_select |=>
		total_interval_count == $past(total_interval_count) + 1'b1
		&& $stable(threshold_ei_count) && $stable(total_error_pulses))
		else $error("clock loss evaluation mishandled");
	sync_drop_a: assert property (sl_in && !cfg.sync_loss_eval_select |=>
		avail_state == AV_CONF && $stable(unavailable_seconds)
		&& $stable(total_interval_count)
		&& sync_loss_intervals == $past(sync_loss_intervals) + 1'b1)
		else $error("sync loss drop mishandled");
	sync_eval_a: assert property (sl_in && cfg.sync_loss_eval_select |=>
		total_interval_count == $past(total_interval_count) + 1'b1
		&& $stable(threshold_ei_count) && $stable(total_error_pulses))
		else $error("sync loss evaluation mishandled");
	avail_book_a: assert property (clean && avail_state == AV_CONF |=>
		available_seconds == $past(available_seconds) + 1'b1
		&& avail_state == AV_CONF) else $error("available not booked");
	unavail_book_a: assert property (hard && avail_state == UN_CONF |=>
		unavailable_seconds == $past(unavailable_seconds) + 1'b1
		&& avail_state == UN_CONF) else $error("unavailable not booked");
	judge_return_a: assert property (clean && avail_state == AV_JUDG |=>
		avail_state == AV_CONF
		&& available_seconds > $past(available_seconds) + 1'b1)
		else $error("judged span not booked");
	error_count_a: assert property (norm && ivl.err_cnt != '0 |=>
		errored_interval_count == $past(errored_interval_count) + 1'b1)
		else $error("error interval miscounted");
endmodule

`default_nettype wire

// ===== dv/front_end_model.sv
/*
 Error detection front end model: turns a bench request into a one
 cycle interval tick carrying the interval data.
 Assumes requests change just after the rising edge of core_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module front_end_model
	import perf_pkg::*;
(
	// Clock and reset
	input  wire logic      core_clk,
	input  wire logic      rst,
	// Request from the bench
	input  wire logic      send,
	input  wire interval_s send_ivl,
	// Interval port
	output logic           interval_tick,
	output interval_s      ivl
);
	// Data is valid only with the tick; between ticks it keeps toggling
	always_ff @(posedge core_clk) begin
		if (rst) begin
			interval_tick <= 1'b0;
			ivl           <= '0;
		end else begin
			interval_tick <= send;
			ivl           <= send ? send_ivl : ~ivl;
		end
	end
endmodule

`default_nettype wire

// ===== dv/test_error_performance_accounting.sv
/*
 Self-checking bench of the error performance accounting block.
 Assumes perf_pkg and the front end model are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module test_error_performance_accounting;
	import perf_pkg::*;
	typedef struct {int n; int c; avail_state_e st; int av; int un;} row_s;
	logic               core_clk, rst, meas_clear, meas_run, send;
	perf_cfg_s          cfg;
	interval_s          send_ivl, ivl;
	logic               interval_tick;
	logic [63:0]        tep, tcp;
	logic [31:0]        eic, tic, ms, pfi, cli, sli, avs, uns, ers, svs;
	logic [31:0]        blk_n, blk_x;
	logic [6:0][31:0]   thr;
	avail_state_e       st;
	int                 errors = 0;
	int                 checked = 0;
	// Count, class (0 clean, 1 heavy errors, 2 power fail), expected
	row_s rows[11] = '{'{1, 0, AV_CONF, 1, 0}, '{1, 1, AV_JUDG, 1, 0},
		'{1, 0, AV_CONF, 3, 0}, '{9, 1, AV_JUDG, 3, 0},
		'{1, 1, UN_CONF, 3, 10}, '{1, 1, UN_CONF, 3, 11},
		'{1, 0, UN_JUDG, 3, 11}, '{1, 1, UN_CONF, 3, 13},
		'{9, 0, UN_JUDG, 3, 13}, '{1, 0, AV_CONF, 13, 13},
		'{1, 2, AV_CONF, 13, 13}};

	////////////////////////////////////////////////////////////////////
	front_end_model fe (.core_clk(core_clk), .rst(rst), .send(send),
		.send_ivl(send_ivl), .interval_tick(interval_tick), .ivl(ivl));
	error_performance_accounting dut (.core_clk(core_clk), .rst(rst),
		.meas_clear(meas_clear), .meas_run(meas_run), .cfg(cfg),
		.interval_tick(interval_tick), .ivl(ivl),
		.total_error_pulses(tep), .total_clock_pulses(tcp),
		.errored_interval_count(eic), .total_interval_count(tic),
		.measure_seconds(ms), .threshold_ei_count(thr),
		.power_fail_intervals(pfi), .clock_loss_intervals(cli),
		.sync_loss_intervals(sli), .available_seconds(avs),
		.unavailable_seconds(uns), .errored_seconds(ers),
		.severe_seconds(svs), .dm_blocks(blk_n), .dm_exceed_blocks(blk_x),
		.avail_state(st));

	////////////////////////////////////////////////////////////////////
	// Class 3 is clock loss, 4 sync loss
	function automatic interval_s mk(int c, logic [31:0] e, logic [39:0] k);
		interval_s v;
		v = '0;
		v.err_cnt = e;
		v.clk_cnt = k;
		v.power_fail = (c == 2);
		v.clock_loss = (c == 3);
		v.sync_loss = (c == 4);
		return v;
	endfunction

	task automatic put(interval_s v);
		@(posedge core_clk);
		send <= 1'b1;
		send_ivl <= v;
	endtask

	// Stop sending and let the last tick land
	task automatic flush();
		@(posedge core_clk);
		send <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	task automatic clr(perf_cfg_s c);
		@(posedge core_clk);
		meas_clear <= 1'b1;
		cfg <= c;
		@(posedge core_clk);
		meas_clear <= 1'b0;
	endtask

	task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
		checked++;
		if (got !== exp) begin
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
			errors++;
		end
	endtask

	task automatic test_done();
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Clock at 40 MHz
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		test_done();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		meas_clear = 1'b0;
		meas_run = 1'b1;
		send = 1'b0;
		send_ivl = '0;
		cfg = '0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("state", AV_CONF, st);
		chk("total", 0, tic);
		foreach (rows[i]) begin
			repeat (rows[i].n) put(mk(rows[i].c, rows[i].c == 1 ? 10 : 0, 1000));
			flush();
			chk("state", rows[i].st, st);
			chk("avail", rows[i].av, avs);
			chk("unavail", rows[i].un, uns);
		end
		chk("seconds", 27, ms);
		chk("thr0", 13, thr[0]);
		chk("thr5", 13, thr[5]);
		chk("thr6", 13, thr[6]);
		chk("intervals", 13, eic);
		chk("total", 26, tic);
		chk("errpulses", 130, tep);
		chk("clkpulses", 26000, tcp);
		chk("powerfail", 1, pfi);
		chk("errored", 1, ers);
		chk("severe", 1, svs);
		// Ticks while stopped are ignored
		@(posedge core_clk);
		meas_run <= 1'b0;
		put(mk(1, 10, 1000));
		flush();
		meas_run <= 1'b1;
		chk("seconds", 27, ms);
		// Alarm intervals evaluated as unavailable
		clr(3'b110);
		put(mk(3, 5, 1000));
		put(mk(0, 0, 1000));
		put(mk(4, 5, 1000));
		put(mk(0, 0, 1000));
		flush();
		chk("avail", 4, avs);
		chk("errored", 2, ers);
		chk("severe", 2, svs);
		chk("total", 4, tic);
		chk("thr0", 0, thr[0]);
		chk("errpulses", 0, tep);
		chk("clockloss", 1, cli);
		chk("syncloss", 1, sli);
		// Alarm intervals dropped, judgment abandoned
		clr(3'b000);
		put(mk(1, 10, 1000));
		put(mk(3, 5, 1000));
		put(mk(1, 10, 1000));
		put(mk(4, 5, 1000));
		flush();
		chk("avail", 0, avs);
		chk("unavail", 0, uns);
		chk("state", AV_CONF, st);
		chk("total", 2, tic);
		chk("errpulses", 20, tep);
		chk("clockloss", 1, cli);
		chk("syncloss", 1, sli);
		// Second threshold set and exact boundary ratios
		clr(3'b001);
		put(mk(0, 1, 1000));
		flush();
		chk("state", AV_JUDG, st);
		put(mk(0, 1, 40'd100_000_000));
		flush();
		chk("thr0", 0, thr[0]);
		chk("thr1", 1, thr[1]);
		chk("thr5", 1, thr[5]);
		chk("thr6", 1, thr[6]);
		// Two blocks of sixty, first one degraded
		clr(3'b000);
		repeat (60) put(mk(0, 1, 1000));
		repeat (60) put(mk(0, 0, 1000));
		flush();
		chk("avail", 120, avs);
		chk("thr1", 60, thr[1]);
		chk("blocks", 2, blk_n);
		chk("exceed", 1, blk_x);
		// Second select: a 1e-7 block is degraded only against 1e-8
		clr(3'b001);
		repeat (60) put(mk(0, 1, 40'd10_000_000));
		flush();
		chk("avail", 60, avs);
		chk("thr4", 0, thr[4]);
		chk("thr5", 60, thr[5]);
		chk("blocks", 1, blk_n);
		chk("exceed", 1, blk_x);
		// Reset in mid-run clears every result
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		put(mk(0, 0, 1000));
		flush();
		chk("avail", 1, avs);
		chk("state", AV_CONF, st);
		chk("exceed", 0, blk_x);
		chk("seconds", 1, ms);
		test_done();
	end
endmodule

bind error_performance_accounting epa_monitor #(
	.CNT_W(CNT_W),
	.SUM_W(SUM_W)
) u_mon (
	.core_clk(core_clk),
	.rst(rst),
	.meas_clear(meas_clear),
	.meas_run(meas_run),
	.cfg(cfg),
	.interval_tick(interval_tick),
	.ivl(ivl),
	.total_error_pulses(total_error_pulses),
	.errored_interval_count(errored_interval_count),
	.total_interval_count(total_interval_count),
	.measure_seconds(measure_seconds),
	.threshold_ei_count(threshold_ei_count),
	.power_fail_intervals(power_fail_intervals),
	.clock_loss_intervals(clock_loss_intervals),
	.sync_loss_intervals(sync_loss_intervals),
	.available_seconds(available_seconds),
	.unavailable_seconds(unavailable_seconds),
	.avail_state(avail_state)
);

`default_nettype wire
